// file: shared/or_ret_defs.svh
/*
 * Constants for the OR / return / rotate execution slice: widths,
 * reset values and cycle counts. Assumes nothing; definitions only.
 */
`ifndef OR_RET_DEFS_SVH
`define OR_RET_DEFS_SVH

`define DATA_W 8
`define MADDR_W 8
`define PC_W_DEF 12
`define ACC_RST 8'h00
`define ZERO_RST 1'b0
`define ROT_MSB 3'h7
`define ROT_LSB 3'h0
`define EXIT_CYCLES 2

`endif

// file: shared/or_ret_pkg.sv
/*
 * Types shared by the execution slice and its surroundings: the decoded
 * operation code and the instruction carrier. Assumes or_ret_defs.svh.
 */
`include "or_ret_defs.svh"

package or_ret_pkg;

	// Decoded operations handled by this slice
	typedef enum logic [2:0] {
		idle_op,
		or_from_memory,
		or_immediate,
		or_to_memory,
		subroutine_exit,
		exit_with_literal,
		interrupt_exit,
		rotate_left
	} op_t;

	// One decoded instruction as handed over by the decode path
	typedef struct packed {
		op_t op;
		logic [`DATA_W-1:0] imm;
		logic [`MADDR_W-1:0] addr;
	} instr_t;

endpackage

// file: logic/or_return_rotate_exec.sv
/*
 * Execution slice for idle, OR, return and rotate-left operations.
 * Assumes data memory reads combinationally on the same clock, the
 * return stack shows its top entry combinationally, and the fetch path
 * honours pc_load and irq_service in the cycle they are high.
 */
// Contract
// - idle_op changes no data, register or flag; execution moves on.
// - OR from memory: working_register |= [m]; zero flag follows result.
// - OR immediate: working_register |= literal; zero flag follows result.
// - or_to_memory: [m] = working_register | [m]; zero flag updated.
// - subroutine_exit pops return address into PC, flags untouched.
// - Exit with literal pops PC and loads literal into working_register.
// - interrupt_exit pops PC and sets global_irq_enable; flags untouched.
// - Pending interrupt at interrupt_exit is serviced before main program.
// - rotate_left: [m] rotated left one bit, bit 7 to bit 0; no flags.
`timescale 1ns/1ps
`include "or_ret_defs.svh"

module or_return_rotate_exec
	import or_ret_pkg::*;
#(
	parameter int PC_W = `PC_W_DEF
) (
	input wire logic clk, // Core clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic instr_valid, // Decoded instruction offered
	input wire instr_t instr, // Decoded instruction
	output logic instr_ready, // Slice accepts an instruction
	output logic [`MADDR_W-1:0] mem_raddr, // Data memory read address
	input wire logic [`DATA_W-1:0] mem_rdata, // Data memory read data
	output logic mem_we, // Data memory write strobe
	output logic [`MADDR_W-1:0] mem_waddr, // Data memory write address
	output logic [`DATA_W-1:0] mem_wdata, // Data memory write data
	input wire logic [PC_W-1:0] stack_top, // Top of return stack
	output logic stack_pop, // Pop return stack
	output logic pc_load, // Load program counter
	output logic [PC_W-1:0] pc_value, // New program counter
	input wire logic irq_pending, // Interrupt request waiting
	output logic global_irq_enable_set, // Set global_irq_enable
	output logic irq_service, // Enter pending interrupt now
	output logic [`DATA_W-1:0] working_register, // Working register
	output logic zero_flag // Zero flag
);

	////////////////////////////////////////////////////////////////////
	// Parameter checks, refused while the design is elaborated
	if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
		$error("PC_W must be between 1 and 16");
	end

	////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic {st_run, st_dummy} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [`DATA_W-1:0] acc;
		logic zero;
		logic we;
		logic [`MADDR_W-1:0] waddr;
		logic [`DATA_W-1:0] wdata;
		logic pop;
		logic load;
		logic [PC_W-1:0] pc;
		logic gie_set;
		logic irq_go;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic take;
	logic [`DATA_W-1:0] or_mem;
	logic [`DATA_W-1:0] rot;

	// Instructions are accepted only outside the dummy cycle
	assign instr_ready = (state_reg.phase == st_run);
	assign take = instr_valid && instr_ready;
	assign mem_raddr = instr.addr;
	assign or_mem = state_reg.acc | mem_rdata;
	assign rot = {mem_rdata[`ROT_MSB-3'h1:`ROT_LSB], mem_rdata[`ROT_MSB]};

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.phase = st_run;
		state_next.we = 1'b0;
		state_next.pop = 1'b0;
		state_next.load = 1'b0;
		state_next.gie_set = 1'b0;
		state_next.irq_go = 1'b0;
		if (take) begin
			unique case (instr.op)
				idle_op: begin
				end
				or_from_memory: begin
					state_next.acc = or_mem;
					state_next.zero = (or_mem == '0);
				end
				or_immediate: begin
					state_next.acc = state_reg.acc | instr.imm;
					state_next.zero = ((state_reg.acc | instr.imm) == '0);
				end
				// OR written back to memory; the write lands in the
				// next cycle, so a dummy cycle keeps a following read fresh
				or_to_memory: begin
					state_next.phase = st_dummy;
					state_next.we = 1'b1;
					state_next.waddr = instr.addr;
					state_next.wdata = or_mem;
					state_next.zero = (or_mem == '0);
				end
				rotate_left: begin
					state_next.phase = st_dummy;
					state_next.we = 1'b1;
					state_next.waddr = instr.addr;
					state_next.wdata = rot;
				end
				// literal also lands in working register
				// a pending request is entered in the dummy cycle
				// dummy cycle while the PC is reloaded
				subroutine_exit, exit_with_literal, interrupt_exit: begin
					state_next.phase = st_dummy;
					state_next.pop = 1'b1;
					state_next.load = 1'b1;
					state_next.pc = stack_top;
					if (instr.op == exit_with_literal) begin
						state_next.acc = instr.imm;
					end
					if (instr.op == interrupt_exit) begin
						state_next.gie_set = 1'b1;
						state_next.irq_go = irq_pending;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '{phase: st_run, acc: `ACC_RST, zero: `ZERO_RST,
				we: 1'b0, waddr: '0, wdata: '0, pop: 1'b0, load: 1'b0,
				pc: '0, gie_set: 1'b0, irq_go: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state flip-flops
	assign mem_we = state_reg.we;
	assign mem_waddr = state_reg.waddr;
	assign mem_wdata = state_reg.wdata;
	assign stack_pop = state_reg.pop;
	assign pc_load = state_reg.load;
	assign pc_value = state_reg.pc;
	assign global_irq_enable_set = state_reg.gie_set;
	assign irq_service = state_reg.irq_go;
	assign working_register = state_reg.acc;
	assign zero_flag = state_reg.zero;

	////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	idle_quiet_a: assert property (
		take && instr.op == idle_op |=> $stable(working_register)
		&& $stable(zero_flag) && !mem_we && !pc_load && instr_ready)
		else $error("idle changed state");

	or_mem_a: assert property (
		take && instr.op == or_from_memory |=>
		working_register == ($past(working_register) | $past(mem_rdata))
		&& zero_flag == (working_register == 8'h00))
		else $error("OR from memory wrong");

	or_imm_a: assert property (
		take && instr.op == or_immediate |=>
		working_register == ($past(working_register) | $past(instr.imm))
		&& zero_flag == (working_register == 8'h00))
		else $error("OR immediate wrong");

	or_store_a: assert property (
		take && instr.op == or_to_memory |=> mem_we
		&& mem_wdata == ($past(working_register) | $past(mem_rdata))
		&& $stable(working_register) && zero_flag == (mem_wdata == 8'h00))
		else $error("OR to memory wrong");

	sub_exit_a: assert property (
		take && instr.op == subroutine_exit |=> pc_load && stack_pop
		&& pc_value == $past(stack_top) && $stable(zero_flag))
		else $error("subroutine exit wrong");

	lit_exit_a: assert property (
		take && instr.op == exit_with_literal |=> pc_load
		&& working_register == $past(instr.imm) && $stable(zero_flag))
		else $error("exit with literal wrong");

	int_exit_a: assert property (
		take && instr.op == interrupt_exit |=> pc_load
		&& global_irq_enable_set && $stable(zero_flag))
		else $error("interrupt exit wrong");

	irq_first_a: assert property (
		take && instr.op == interrupt_exit && irq_pending |=> irq_service)
		else $error("pending interrupt not serviced");

	rot_left_a: assert property (
		take && instr.op == rotate_left |=> mem_we
		&& mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
		&& $stable(zero_flag) && $stable(working_register))
		else $error("rotate left wrong");

	exit_dummy_a: assert property (
		take && (instr.op == subroutine_exit || instr.op == interrupt_exit)
		|=> !instr_ready ##1 instr_ready && !pc_load)
		else $error("return not two cycles");

endmodule // or_return_rotate_exec

// file: test/or_ret_partner.sv
/*
 * Far-side model: data memory and return stack.
 * Assumes writes land on the rising edge that ends the write pulse cycle.
 */
`timescale 1ns/1ps
`include "or_ret_defs.svh"
module or_ret_partner #(
	parameter int PC_W = `PC_W_DEF
) (
	input wire logic clk, // Core clock
	input wire logic [`MADDR_W-1:0] mem_raddr, // Read address
	output logic [`DATA_W-1:0] mem_rdata, // Read data, combinational
	input wire logic mem_we, // Write pulse
	input wire logic [`MADDR_W-1:0] mem_waddr, // Write address
	input wire logic [`DATA_W-1:0] mem_wdata, // Write data
	input wire logic stack_pop, // Pop pulse
	output logic [PC_W-1:0] stack_top // Top entry
);
	logic [`DATA_W-1:0] mem [256];
	logic [PC_W-1:0] top_reg = PC_W'(12'h5A3);
	////////////////////////////////////////////////////////////////////
	// Low quarter zero so OR results can reach zero
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = (i < 64) ? 8'h00 : 8'(i * 37);
		end
	end
	assign mem_rdata = mem[mem_raddr];
	assign stack_top = top_reg;
	// Each pop shows a new return address, so stale loads show up
	always @(posedge clk) begin
		if (mem_we) mem[mem_waddr] <= mem_wdata;
		if (stack_pop) top_reg <= PC_W'(top_reg * 5 + 3);
	end
endmodule // or_ret_partner

// file: test/tb_top.sv
/*
 * Self-checking bench for the execution slice, random instruction stream.
 * Assumes the partner model answers memory and stack reads at once.
 */
`timescale 1ns/1ps
`include "or_ret_defs.svh"
module tb_top
	import or_ret_pkg::*;
;
	localparam int PW = `PC_W_DEF;
	localparam int VW = 31 + PW;
	logic clk = 1'b0;
	logic resetn, instr_valid, instr_ready, mem_we, stack_pop, pc_load;
	logic irq_pending, global_irq_enable_set, irq_service, zero_flag;
	instr_t instr;
	logic [7:0] mem_raddr, mem_rdata, mem_waddr, mem_wdata, working_register;
	logic [PW-1:0] stack_top, pc_value, pc_m;
	logic [VW-1:0] q[$];
	int n_errors, checks_done;
	int seed = 32'hebde1967;
	logic take = 1'b0, take_d = 1'b0, z_m, we, pp, ge, sv;
	logic [7:0] a_m, wa_m, wd_m, m, r;
	////////////////////////////////////////////////////////////////////
	always #5 clk = ~clk;
	or_return_rotate_exec #(.PC_W(PW)) dut (.clk(clk), .resetn(resetn),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
		.mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
		.mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .stack_top(stack_top),
		.stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
		.irq_pending(irq_pending), .irq_service(irq_service),
		.global_irq_enable_set(global_irq_enable_set),
		.working_register(working_register), .zero_flag(zero_flag));
	or_ret_partner #(.PC_W(PW)) pm (.clk(clk), .mem_raddr(mem_raddr),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
		.mem_wdata(mem_wdata), .stack_pop(stack_pop), .stack_top(stack_top));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [VW-1:0] o, input logic [VW-1:0] e);
		checks_done++;
		if (o !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, o, e);
		end
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Monitor: a taken op shows all effects one cycle later
	always @(posedge clk) take_d <= take;
	always @(negedge clk) begin
		if (take_d) begin
			chk({working_register, zero_flag, mem_we, mem_waddr, mem_wdata,
				stack_pop, pc_load, pc_value, global_irq_enable_set,
				irq_service, instr_ready}, q.pop_front());
		end else if (resetn) begin
			chk(VW'({mem_we, stack_pop, pc_load, global_irq_enable_set,
				irq_service, instr_ready}), VW'(6'h01));
		end
	end
	// Watchdog well beyond the planned stream length
	initial begin
		#20000;
		n_errors++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////
	// Driver: a refused request is held while instr_ready is low, then redrawn
	initial begin
		resetn = 1'b0; instr_valid = 1'b0; instr = '0; irq_pending = 1'b0;
		a_m = 8'h00; z_m = 1'b0; wa_m = 8'h00; wd_m = 8'h00; pc_m = '0;
		repeat (20) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		for (int i = 0; i < 400; i++) begin
			@(negedge clk);
			if (!(instr_valid && !instr_ready)) begin
				instr_valid = ($random(seed) & 3) != 0;
				instr.op = op_t'(3'($random(seed)));
				r = 8'($random(seed));
				instr.imm = (r[7:4] == 4'h0) ? 8'h00 : r;
				instr.addr = 8'($random(seed));
			end
			irq_pending = 1'($random(seed));
			#1 take = instr_valid && instr_ready;
			if (take) begin
				// Read the model's array, so a wrong read address shows up
				m = pm.mem[instr.addr]; we = 0; pp = 0; ge = 0; sv = 0;
				case (instr.op)
					or_from_memory: begin a_m = a_m | m; z_m = a_m == 0; end
					or_immediate: begin a_m = a_m | instr.imm; z_m = a_m == 0; end
					or_to_memory: begin we = 1; wd_m = a_m | m; z_m = wd_m == 0; end
					rotate_left: begin we = 1; wd_m = {m[6:0], m[7]}; end
					idle_op: ;
					default: begin pp = 1; pc_m = stack_top; end
				endcase
				if (instr.op == exit_with_literal) a_m = instr.imm;
				if (instr.op == interrupt_exit) begin ge = 1; sv = irq_pending; end
				if (we) wa_m = instr.addr;
				q.push_back({a_m, z_m, we, wa_m, wd_m, pp, pp, pc_m, ge, sv,
					!(we || pp)});
			end
		end
		// Stop offering, so no op is taken without a note in the queue
		@(negedge clk);
		instr_valid = 1'b0;
		take = 1'b0;
		repeat (3) @(negedge clk);
		test_done();
	end
endmodule // tb_top
